// [src/ledfm_core.sv]
// protection and fault management core of a six channel led driver
// ---------------------------------------------------------------
// Overview of operation
// - soft-start limit begins at 275mA, seven 275mA steps up to 2.2A.
// - steps last at least 1ms, stretched at low dimming rate and small duty.
// - boost stays idle until input protection fet is fully on.
// - each switching cycle ends on-phase when switch current exceeds limit.
// - input current above about 2A shuts down all channels.
// - apparent faults during transients never fault out a string.
// - every led fault is reported in status register 0x02.
// - mask register 0x09 shows failed channels; host writes to disable them.
// - channel voltage above about 7.5V is a short and gets disabled.
// - channel reaching target is good; good channel dropping below is open.
// - overvoltage or lower temperature marks every not-good channel open.
// - open channel disabled after time-out, shorter above lower temperature.
// - raised forward voltage string stays on unless overvoltage is hit.
// - ovp sense rising then falling below 20% switches off input fet.
// - undervoltage lockout stops switching and resets until supply returns.
// - at 130C low-current channels are open, disabled after 800us.
// - each 150C hit stops boost, restarts near 100C derated 75/50/25%.
// - device stays active across thermal cycles unless enable drops.
// - open or short time-out expires after six dimming pwm cycles.
// - ground short at power-up gives permanent shutdown 31ms later.
// ---------------------------------------------------------------
module ledfm_core
  import ledfm_pkg::*;
(
  input wire logic core_clk, // 10 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic enable, // enable pin level
  input wire ledfm_sense_t sense, // analog comparator results
  input wire logic [NUM_CH-1:0] ch_at_target, // channel current at target
  input wire logic [NUM_CH-1:0] ch_over_v, // channel voltage above 7.5 V
  input wire logic pwm_cycle_start, // one pulse per dimming pwm cycle
  input wire logic pwm_duty_low, // dimming duty is small
  input wire logic led_stable, // feedback says loop is settled
  input wire ledfm_reg_req_t reg_req, // register access strobes
  output logic [7:0] reg_rdata_ff, // read data, valid after rd
  output logic [2:0] ilim_code_ff, // current limit code
  output logic boost_en_ff, // boost may switch
  output logic sw_off_ff, // end on-phase of this cycle
  output logic [NUM_CH-1:0] ch_en_ff, // current sink enables
  output logic [1:0] derate_ff, // dc current derating step
  output logic fet_gate_off_ff // switch off input protection fet
);

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  ledfm_state_t state_ff, nxt_state;
  logic [31:0] ss_cnt_ff;
  logic [31:0] pup_cnt_ff;
  logic dead_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LEDFM_IDLE: begin
        if (enable && sense.fet_on && !dead_ff) begin
          nxt_state = LEDFM_SOFT;
        end
      end
      LEDFM_SOFT, LEDFM_RUN: begin
        if (sense.temp_high) begin
          nxt_state = LEDFM_HOT;
        end else if (state_ff == LEDFM_SOFT && ilim_code_ff == ILIM_FINAL) begin
          nxt_state = LEDFM_RUN;
        end
      end
      LEDFM_HOT: begin
        if (sense.temp_cool) begin
          nxt_state = LEDFM_SOFT;
        end
      end
      LEDFM_DEAD: nxt_state = LEDFM_DEAD;
      default: nxt_state = LEDFM_IDLE;
    endcase
    if (!enable || sense.lockout || !sense.fet_on) begin
      nxt_state = LEDFM_IDLE;
    end
    if (dead_ff || sense.input_overcur) begin
      nxt_state = dead_ff ? LEDFM_DEAD : LEDFM_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= LEDFM_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // soft-start current limit stepping
  // ---------------------------------------------------------------
  // stretch at low duty: when duty is small a finished step waits for a pwm pulse
  // so a slow dimming rate lengthens each step beyond the 1 ms floor
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ss_cnt_ff <= 32'h0;
      ilim_code_ff <= ILIM_FIRST;
    end else if (state_ff == LEDFM_IDLE || state_ff == LEDFM_HOT) begin
      ss_cnt_ff <= 32'h0;
      ilim_code_ff <= ILIM_FIRST;
    end else if (state_ff == LEDFM_SOFT && ilim_code_ff != ILIM_FINAL) begin
      if (ss_cnt_ff >= SS_STEP_CYC - 1 && (!pwm_duty_low || pwm_cycle_start)) begin
        ss_cnt_ff <= 32'h0;
        ilim_code_ff <= ilim_code_ff + 3'h1;
      end else if (ss_cnt_ff < SS_STEP_CYC - 1) begin
        ss_cnt_ff <= ss_cnt_ff + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // boost switching control
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boost_en_ff <= 1'b0;
      sw_off_ff <= 1'b0;
    end else begin
      boost_en_ff <= (nxt_state == LEDFM_SOFT || nxt_state == LEDFM_RUN);
      sw_off_ff <= sense.sw_over_lim || !(nxt_state == LEDFM_SOFT || nxt_state == LEDFM_RUN);
    end
  end

  // ---------------------------------------------------------------
  // thermal derating
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      derate_ff <= DERATE_FULL;
    end else if (state_ff == LEDFM_IDLE) begin
      derate_ff <= DERATE_FULL;
    end else if (state_ff != LEDFM_HOT && nxt_state == LEDFM_HOT && derate_ff != DERATE_MIN) begin
      derate_ff <= derate_ff - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // ground short and ovp collapse
  // ---------------------------------------------------------------
  logic ovp_seen_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pup_cnt_ff <= 32'h0;
      dead_ff <= 1'b0;
    end else if (pup_cnt_ff < GND_SHORT_CYC) begin
      pup_cnt_ff <= pup_cnt_ff + 32'h1;
    end else if (pup_cnt_ff == GND_SHORT_CYC && sense.gnd_short) begin
      dead_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovp_seen_ff <= 1'b0;
      fet_gate_off_ff <= 1'b0;
    end else begin
      if (!sense.ovp_low20) begin
        ovp_seen_ff <= 1'b1;
      end
      if ((ovp_seen_ff && sense.ovp_low20) || dead_ff) begin
        fet_gate_off_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // per channel open and short tracking
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] good_ff, open_ff, short_ff, fail_ff;
  logic [7:0] mask_ff;
  logic [7:0] status_ff;
  logic running;
  assign running = (state_ff == LEDFM_SOFT || state_ff == LEDFM_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [2:0] pwm_cnt_ff;
      logic [31:0] hot_cnt_ff;
      logic pend;
      assign pend = open_ff[gi] || short_ff[gi];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          good_ff[gi] <= 1'b0;
          open_ff[gi] <= 1'b0;
          short_ff[gi] <= 1'b0;
          fail_ff[gi] <= 1'b0;
          pwm_cnt_ff <= 3'h0;
          hot_cnt_ff <= 32'h0;
        end else if (!running || mask_ff[gi] || fail_ff[gi]) begin
          good_ff[gi] <= 1'b0;
          open_ff[gi] <= 1'b0;
          short_ff[gi] <= 1'b0;
          pwm_cnt_ff <= 3'h0;
          hot_cnt_ff <= 32'h0;
        end else begin
          if (ch_at_target[gi]) begin
            good_ff[gi] <= 1'b1;
            open_ff[gi] <= 1'b0;
          end else if (good_ff[gi] && led_stable) begin
            open_ff[gi] <= 1'b1;
          end else if (!good_ff[gi] && (sense.ovp_trip || sense.temp_low)) begin
            open_ff[gi] <= 1'b1;
          end
          short_ff[gi] <= ch_over_v[gi] && led_stable;
          if (!pend) begin
            pwm_cnt_ff <= 3'h0;
            hot_cnt_ff <= 32'h0;
          end else begin
            if (pwm_cycle_start && pwm_cnt_ff != PWM_TO_CYCLES) begin
              pwm_cnt_ff <= pwm_cnt_ff + 3'h1;
            end
            if (hot_cnt_ff != HOT_TO_CYC) begin
              hot_cnt_ff <= hot_cnt_ff + 32'h1;
            end
            if (pwm_cnt_ff == PWM_TO_CYCLES ||
                (sense.temp_low && open_ff[gi] && hot_cnt_ff == HOT_TO_CYC)) begin
              fail_ff[gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // channel enables
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ch_en_ff <= '0;
    end else if (sense.input_overcur || nxt_state != LEDFM_SOFT && nxt_state != LEDFM_RUN) begin
      ch_en_ff <= '0;
    end else begin
      ch_en_ff <= ~(mask_ff[NUM_CH-1:0] | fail_ff);
    end
  end

  // ---------------------------------------------------------------
  // registers: status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_ff <= MASK_RESET;
    end else if (reg_req.wr && reg_req.addr == REG_OUT_MASK) begin
      // host disables channels; a failed channel stays masked, so that
      // clearing its bit never reports the same failure a second time
      mask_ff <= reg_req.wdata | {2'h0, fail_ff};
    end else begin
      mask_ff[NUM_CH-1:0] <= mask_ff[NUM_CH-1:0] | fail_ff;
    end
  end

  // sticky until read; a new event wins over the read clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= ((reg_req.rd && reg_req.addr == REG_FAULT_STATUS) ? 8'h00 : status_ff)
        | {sense.temp_high, sense.ovp_trip, 6'h00}
        | {2'h0, fail_ff & ~mask_ff[NUM_CH-1:0]};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        REG_FAULT_STATUS: reg_rdata_ff <= status_ff;
        REG_OUT_MASK: reg_rdata_ff <= mask_ff;
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end

endmodule

// [src/ledfm_pkg.sv]
// package of constants and types for the led fault manager
package ledfm_pkg;
  localparam int unsigned NUM_CH = 6;
  localparam int unsigned CLK_HZ = 10_000_000;
  // register offsets on the serial management port
  localparam logic [7:0] REG_FAULT_STATUS = 8'h02;
  localparam logic [7:0] REG_OUT_MASK = 8'h09;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // fault_status field positions
  localparam int unsigned FS_CH_LSB = 0;
  localparam int unsigned FS_OVP_BIT = 6;
  localparam int unsigned FS_OTP_BIT = 7;
  // current limit: code n means (n+1) x 275 mA, 7 = 2.2 A
  localparam logic [2:0] ILIM_FIRST = 3'h0;
  localparam logic [2:0] ILIM_FINAL = 3'h7;
  // soft-start step time: 7 ms over 7 steps, 1 ms each
  localparam int unsigned SS_STEP_US = 1000;
  localparam int unsigned SS_STEP_CYC = SS_STEP_US * (CLK_HZ / 1_000_000);
  // hot open time-out 800 us
  localparam int unsigned HOT_TO_US = 800;
  localparam int unsigned HOT_TO_CYC = HOT_TO_US * (CLK_HZ / 1_000_000);
  // normal open/short time-out in dimming pwm cycles
  localparam logic [2:0] PWM_TO_CYCLES = 3'h6;
  // permanent shutdown delay after power-up, 31 ms
  localparam int unsigned GND_SHORT_MS = 31;
  localparam int unsigned GND_SHORT_CYC = GND_SHORT_MS * (CLK_HZ / 1000);
  // derating codes: 3=100%, 2=75%, 1=50%, 0=25%
  localparam logic [1:0] DERATE_FULL = 2'h3;
  localparam logic [1:0] DERATE_MIN = 2'h0;
  typedef enum logic [4:0] {
    LEDFM_IDLE = 5'h01,
    LEDFM_SOFT = 5'h02,
    LEDFM_RUN = 5'h04,
    LEDFM_HOT = 5'h08,
    LEDFM_DEAD = 5'h10
  } ledfm_state_t;
  // register access strobe group
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ledfm_reg_req_t;
  // analog comparator inputs, one bundle
  typedef struct packed {
    logic fet_on;
    logic sw_over_lim;
    logic input_overcur;
    logic ovp_trip;
    logic ovp_low20;
    logic lockout;
    logic temp_low;
    logic temp_high;
    logic temp_cool;
    logic gnd_short;
  } ledfm_sense_t;
endpackage

// [tb/ledfm_core_sva.sv]
// assertion checker bound to the led fault manager core
module ledfm_chk
  import ledfm_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic enable, // enable
  input wire ledfm_sense_t sense, // sense
  input wire logic [NUM_CH-1:0] ch_at_target, // good
  input wire logic [NUM_CH-1:0] ch_over_v, // short
  input wire logic pwm_cycle_start, // pwm
  input wire logic pwm_duty_low, // duty
  input wire logic led_stable, // settled
  input wire ledfm_reg_req_t reg_req, // bus
  input wire logic [7:0] reg_rdata_ff, // rdata
  input wire logic [2:0] ilim_code_ff, // limit
  input wire logic boost_en_ff, // boost
  input wire logic sw_off_ff, // cut
  input wire logic [NUM_CH-1:0] ch_en_ff, // sinks
  input wire logic [1:0] derate_ff, // derate
  input wire logic fet_gate_off_ff // fet off
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic [15:0] gap_ff;
  // cycles since the limit last moved; saturates so a long run never wraps
  always_ff @(posedge core_clk or posedge rst)
    if (rst) gap_ff <= '0;
    else gap_ff <= $changed(ilim_code_ff) ? '0 : gap_ff + 16'(gap_ff != '1);
  property p_step;
    $changed(ilim_code_ff) |->
      ilim_code_ff == $past(ilim_code_ff) + 3'h1 || ilim_code_ff == ILIM_FIRST;
  endproperty
  a_step: assert property (p_step) else $error("limit jump");
  property p_gap;
    $changed(ilim_code_ff) && ilim_code_ff != ILIM_FIRST |-> gap_ff >= SS_STEP_CYC - 1;
  endproperty
  a_gap: assert property (p_gap) else $error("step too soon");
  property p_fet;
    $rose(boost_en_ff) |-> $past(sense.fet_on);
  endproperty
  a_fet: assert property (p_fet) else $error("boost before fet");
  property p_cut;
    sense.sw_over_lim && boost_en_ff |-> ##[1:3] sw_off_ff;
  endproperty
  a_cut: assert property (p_cut) else $error("no cut");
  property p_oc;
    sense.input_overcur |-> ##[1:3] ch_en_ff == '0;
  endproperty
  a_oc: assert property (p_oc) else $error("sinks on");
  property p_lock;
    sense.lockout |-> ##[1:3] !boost_en_ff;
  endproperty
  a_lock: assert property (p_lock) else $error("boost in lockout");
  property p_hot;
    sense.temp_high |-> ##[1:3] !boost_en_ff && ch_en_ff == '0;
  endproperty
  a_hot: assert property (p_hot) else $error("hot not stopped");
  property p_der;
    $changed(derate_ff) && derate_ff != DERATE_FULL |-> derate_ff == $past(derate_ff) - 2'h1;
  endproperty
  a_der: assert property (p_der) else $error("derate jump");
  c_run: cover property (ilim_code_ff == ILIM_FINAL);
  c_stop: cover property ($fell(boost_en_ff));
  c_fet: cover property ($rose(fet_gate_off_ff));
endmodule
bind ledfm_core ledfm_chk u_chk (.*);

// [tb/ledfm_far_end.sv]
// model of the input protection fet and the dimming pwm source
module ledfm_far_end
  import ledfm_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic fet_allow, // supply applied
  input wire logic fet_gate_off, // gate pulled off
  input wire logic pwm_run, // dimming on
  output logic fet_on, // fet fully on
  output logic pwm_cycle_start // period pulse
);
  logic [4:0] ramp_ff;
  logic [5:0] pwm_ff;
  // slow gate ramp, dropped at once when the gate is pulled off
  always_ff @(posedge core_clk or posedge rst)
    if (rst) ramp_ff <= '0;
    else if (fet_gate_off || !fet_allow) ramp_ff <= '0;
    else if (ramp_ff != 5'h14) ramp_ff <= ramp_ff + 5'h01;
  assign fet_on = ramp_ff == 5'h14;
  // 50 cycle dimming period; stands still while dimming is off
  always_ff @(posedge core_clk or posedge rst)
    if (rst || !pwm_run) pwm_ff <= '0;
    else pwm_ff <= pwm_ff == 6'h31 ? '0 : pwm_ff + 6'h01;
  assign pwm_cycle_start = pwm_run && pwm_ff == 6'h31;
endmodule

// [tb/tb_ledfm_core.sv]
// self-checking bench for the led fault manager core
`define CHK(a, e) begin #1; checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %0t got %h want %h", $time, a, e); end end
module tb_ledfm_core
  import ledfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, enable = 0, fet_allow = 0, pwm_run = 0, led_stable = 0;
  logic duty_low = 0;
  logic swl = 0, ocur = 0, overvoltage_trip_sense = 0, low20 = 1, lock = 0, tlow = 0, thigh = 0, tcool = 0;
  logic fet_on, pwm_cycle_start, boost_en_ff, sw_off_ff, fet_gate_off_ff;
  logic [NUM_CH-1:0] ch_at_target = 6'h2f, ch_over_v = 6'h00, ch_en_ff;
  logic [7:0] reg_rdata_ff;
  logic [2:0] ilim_code_ff;
  logic [1:0] derate_ff;
  ledfm_reg_req_t reg_req = '0;
  ledfm_sense_t sense;
  int n_fail = 0, checks = 0;
  // ground short tied off: its permanent shutdown would only come at 31 ms, after the run ends
  assign sense = {fet_on, swl, ocur, overvoltage_trip_sense, low20, lock, tlow, thigh, tcool, 1'b0};
  ledfm_core dut (.core_clk(core_clk), .rst(rst), .enable(enable), .sense(sense),
    .ch_at_target(ch_at_target), .ch_over_v(ch_over_v), .pwm_cycle_start(pwm_cycle_start),
    .pwm_duty_low(duty_low), .led_stable(led_stable), .reg_req(reg_req),
    .reg_rdata_ff(reg_rdata_ff), .ilim_code_ff(ilim_code_ff), .boost_en_ff(boost_en_ff),
    .sw_off_ff(sw_off_ff), .ch_en_ff(ch_en_ff), .derate_ff(derate_ff),
    .fet_gate_off_ff(fet_gate_off_ff));
  ledfm_far_end u_far (.core_clk(core_clk), .rst(rst), .fet_allow(fet_allow),
    .fet_gate_off(fet_gate_off_ff), .pwm_run(pwm_run), .fet_on(fet_on),
    .pwm_cycle_start(pwm_cycle_start));
  // 100 ns clock
  initial forever #50 core_clk = ~core_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // a quiet edge first, then one strobe cycle, so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    reg_req <= {1'b1, 1'b0, a, d};
    cyc(1);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    cyc(1);
    reg_req.rd <= 1'b0;
    cyc(1);
    `CHK(reg_rdata_ff, e)
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    rd(REG_OUT_MASK, MASK_RESET);
    rd(REG_FAULT_STATUS, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    cyc(1);
    enable <= 1'b1;
    cyc(20);
    `CHK(boost_en_ff, 1'b0)
    cyc(1);
    fet_allow <= 1'b1;
    low20 <= 1'b0;
    cyc(SS_STEP_CYC / 2);
    `CHK(boost_en_ff, 1'b1)
    `CHK(ilim_code_ff, ILIM_FIRST)
    for (int k = 1; k <= 6; k++) begin
      cyc(SS_STEP_CYC);
      `CHK(ilim_code_ff, 3'(k))
    end
    // small duty with no pwm pulses: the last step must wait for a pulse
    cyc(1);
    duty_low <= 1'b1;
    cyc(SS_STEP_CYC);
    `CHK(ilim_code_ff, 3'h6)
    cyc(1);
    pwm_run <= 1'b1;
    cyc(60);
    `CHK(ilim_code_ff, ILIM_FINAL)
    `CHK(sw_off_ff, 1'b0)
    cyc(1);
    duty_low <= 1'b0;
    pwm_run <= 1'b0;
    swl <= 1'b1;
    cyc(3);
    `CHK(sw_off_ff, 1'b1)
    cyc(1);
    swl <= 1'b0;
    pwm_run <= 1'b1;
    ch_over_v <= 6'h02;
    cyc(500);
    `CHK(ch_en_ff, 6'h3f)
    cyc(1);
    ch_over_v <= 6'h04;
    led_stable <= 1'b1;
    cyc(100);
    `CHK(ch_en_ff, 6'h3f)
    cyc(400);
    `CHK(ch_en_ff, 6'h3b)
    rd(REG_FAULT_STATUS, 8'h04);
    rd(REG_FAULT_STATUS, 8'h00);
    rd(REG_OUT_MASK, 8'h04);
    wr(REG_OUT_MASK, 8'h08);
    cyc(3);
    `CHK(ch_en_ff, 6'h33)
    rd(REG_OUT_MASK, 8'h0c);
    // no pwm pulses here, so only the hot time-out can expire
    cyc(1);
    pwm_run <= 1'b0;
    tlow <= 1'b1;
    cyc(4000);
    `CHK(ch_en_ff, 6'h33)
    cyc(5000);
    `CHK(ch_en_ff, 6'h23)
    rd(REG_FAULT_STATUS, 8'h10);
    cyc(1);
    tlow <= 1'b0;
    thigh <= 1'b1;
    cyc(3);
    `CHK({boost_en_ff, ch_en_ff, derate_ff}, 9'h002)
    rd(REG_FAULT_STATUS, 8'h80);
    cyc(1);
    thigh <= 1'b0;
    tcool <= 1'b1;
    cyc(4);
    `CHK({boost_en_ff, ilim_code_ff}, {1'b1, ILIM_FIRST})
    cyc(1);
    tcool <= 1'b0;
    ocur <= 1'b1;
    cyc(3);
    `CHK(ch_en_ff, 6'h00)
    cyc(1);
    ocur <= 1'b0;
    cyc(3);
    `CHK(boost_en_ff, 1'b1)
    cyc(1);
    lock <= 1'b1;
    cyc(3);
    `CHK(boost_en_ff, 1'b0)
    cyc(1);
    lock <= 1'b0;
    overvoltage_trip_sense <= 1'b1;
    cyc(3);
    `CHK(fet_gate_off_ff, 1'b0)
    cyc(1);
    overvoltage_trip_sense <= 1'b0;
    low20 <= 1'b1;
    cyc(3);
    `CHK(fet_gate_off_ff, 1'b1)
    report_and_stop();
  end
  // the tests take about 8.5 ms; cut a hang at 9.5 ms
  initial begin
    #9_500_000;
    n_fail++;
    report_and_stop();
  end
endmodule
